/* File: verilog/xcp_event_unit.sv */
// Processor event unit: interrupts, coprocessor handshake and reset pin states
// Operation
// RULE_01 - Maskable request ignored while enable clear
// RULE_02 - Two acknowledge cycles read 8-bit vector
// RULE_03 - Requester holds request until acknowledge begins
// RULE_04 - Request sampled each cycle, two before end
// RULE_05 - Maskable request level sensitive, active high
// RULE_06 - Non-maskable uses internal vector two
// RULE_07 - Non-maskable performs no acknowledge cycles
// RULE_08 - Non-maskable ignores interrupt enable bit
// RULE_09 - Non-maskable synchronised then rising-edge detected
// RULE_10 - Non-maskable low four, high four clocks
// RULE_11 - Coprocessor raises operand request, maybe asynchronous
// RULE_12 - Operand ack low during transfer
// RULE_13 - Operand ack floats high under bus grant
// RULE_14 - Busy stalls wait and coprocessor instructions; code stalls coprocessor instructions only
// RULE_15 - Interrupts still taken while stalled on busy
// RULE_16 - Error during coprocessor instruction raises interrupt
// RULE_17 - Busy and error low active, asynchronous
// RULE_18 - Reset high clears logic, held over sixteen
// RULE_19 - Reset drives status, ack, address, enables high
// RULE_20 - Reset drives select lines and grant low
// RULE_21 - About fifty clocks initialisation after reset
// RULE_22 - Grant ack low only when request inactive; code also holds it low during acknowledge cycles and reset
// RULE_23 - Asynchronous inputs pass two-stage synchroniser
`timescale 1ns/100ps
module xcp_event_unit #(
    parameter int INIT_CLKS = xcp_pkg::INIT_CLKS
) (
    // Clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    // Link to system partner
    xcp_link_if.dev          LINK,
    // Core side controls
    input  wire logic        INT_ENABLE_I,
    input  wire logic        COPROC_OPCODE_INSTR_I,
    input  wire logic        OPERAND_XFER_I,
    // Core side results
    output logic             INIT_DONE_O,
    output logic             STALL_O,
    output logic             INT_TAKEN_O,
    output logic [7:0]       INT_VECTOR_O
);
    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_INIT  = 5'h01,  // Initialisation after reset
        ST_RUN   = 5'h02,  // Executing
        ST_ACK1  = 5'h04,  // First acknowledge cycle
        ST_ACK2  = 5'h08,  // Second acknowledge cycle, vector read
        ST_RESET = 5'h10   // Reset pin held
    } xcp_state_t;

    xcp_state_t state;          // Current state
    xcp_state_t next_state;     // Next state
    logic [5:0] init_cnt;       // Initialisation counter
    logic       cyc_cnt;        // Clock within acknowledge cycle
    logic [4:0] sync_q;         // Synchronised asynchronous inputs
    logic       irq_s;          // Maskable request, synchronised
    logic       nmi_s;          // Non-maskable, synchronised
    logic       preq_s;         // Operand request, synchronised
    logic       busy_s;         // Busy, high means busy
    logic       err_s;          // Error, high means error
    logic       nmi_prev;       // Previous synchronised non-maskable
    logic       nmi_pend;       // Non-maskable pending
    logic       hold_s;         // Bus request, registered
    logic       rst_s;          // Reset pin, registered

    // RULE_23 two-stage synchronisers
    xcp_sync #(.W(5)) u_sync (
        .clk_i     (CLK_SYS_I),
        .rst_n_i   (RST_N_I),
        .d_i       ({LINK.maskable_irq, LINK.nmi, LINK.ext_operand_request,
                     LINK.busy_n, LINK.error_n}),
        .rst_val_i (5'h03),
        .q_o       (sync_q)
    );
    // RULE_05 level sensitive request
    assign irq_s  = sync_q[4];
    assign nmi_s  = sync_q[3];
    assign preq_s = sync_q[2];
    // RULE_17 busy and error active low
    assign busy_s = ~sync_q[1];
    assign err_s  = ~sync_q[0];

    // Reset pin and bus request registers
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            rst_s  <= 1'b1;
            hold_s <= 1'b0;
        end else begin
            rst_s  <= LINK.reset;
            hold_s <= LINK.hold;
        end
    end

    // RULE_09 edge detect after sync
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I || rst_s) begin
            nmi_prev <= 1'b0;
            nmi_pend <= 1'b0;
        end else begin
            nmi_prev <= nmi_s;
            // Set wins over the clear taken in the same cycle
            if (nmi_s && !nmi_prev) begin
                nmi_pend <= 1'b1;
            end else if (state == ST_RUN) begin
                nmi_pend <= 1'b0;
            end
        end
    end

    // Next-state logic
    always_comb begin
        next_state = state;
        case (state)
            ST_RESET: begin
                if (!rst_s) begin
                    next_state = ST_INIT;
                end
            end
            // RULE_21 initialisation delay
            ST_INIT: begin
                if (init_cnt == 6'(INIT_CLKS - 1)) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                // RULE_04 request sampled every clock
                // RULE_01 mask maskable request
                if (!nmi_pend && irq_s && INT_ENABLE_I && !hold_s) begin
                    next_state = ST_ACK1;
                end
            end
            ST_ACK1: begin
                if (cyc_cnt) begin
                    next_state = ST_ACK2;
                end
            end
            ST_ACK2: begin
                if (cyc_cnt) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RESET;
        endcase
        // RULE_18 reset overrides everything
        if (rst_s) begin
            next_state = ST_RESET;
        end
    end

    // State register
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Initialisation and acknowledge-cycle counters
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I || state != next_state) begin
            init_cnt <= 6'h00;
            cyc_cnt  <= 1'b0;
        end else begin
            init_cnt <= init_cnt + 6'h01;
            cyc_cnt  <= ~cyc_cnt;
        end
    end

    // Interrupt take and vector register
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I || rst_s) begin
            INT_TAKEN_O  <= 1'b0;
            INT_VECTOR_O <= 8'h00;
        end else begin
            INT_TAKEN_O <= 1'b0;
            // RULE_06 RULE_07 RULE_08 internal vector, no ack
            // RULE_15 taken even while stalled
            if (state == ST_RUN && nmi_pend) begin
                INT_TAKEN_O  <= 1'b1;
                INT_VECTOR_O <= xcp_pkg::NMI_VECTOR;
            // RULE_16 processor extension interrupt
            end else if (state == ST_RUN && COPROC_OPCODE_INSTR_I && err_s) begin
                INT_TAKEN_O  <= 1'b1;
                INT_VECTOR_O <= xcp_pkg::PEXT_VECTOR;
            // RULE_02 vector read in second cycle
            end else if (state == ST_ACK2 && cyc_cnt) begin
                INT_TAKEN_O  <= 1'b1;
                INT_VECTOR_O <= LINK.vector;
            end
        end
    end

    // RULE_14 stall on busy
    assign STALL_O     = (state == ST_RUN) && COPROC_OPCODE_INSTR_I && busy_s && !err_s;
    assign INIT_DONE_O = (state != ST_INIT) && (state != ST_RESET);

    // Bus pin drive
    always_comb begin
        LINK.inta_strobe         = (state == ST_ACK1) || (state == ST_ACK2);
        LINK.lock_n              = !LINK.inta_strobe;
        LINK.bus_status_lines    = LINK.inta_strobe ? 2'h0 : xcp_pkg::STATUS_RST;
        LINK.mem_io_select       = 1'b0;
        LINK.fetch_or_ack_select = !LINK.inta_strobe;
        LINK.addr                = xcp_pkg::ADDR_RST;
        LINK.upper_byte_enable_n = 1'b1;
        // RULE_22 grant follows request in run and initialisation states only
        LINK.bus_grant_ack       = hold_s && (state == ST_RUN || state == ST_INIT);
        // RULE_11 RULE_12 ack low during transfer
        LINK.ext_operand_ack_n   = !(preq_s && OPERAND_XFER_I && state == ST_RUN);
        // RULE_13 float under bus grant
        LINK.ext_operand_ack_oe  = !LINK.bus_grant_ack;
        // RULE_19 RULE_20 reset pin states
        // Follow the registered pin too, so pins settle a clock before the state does
        if (state == ST_RESET || rst_s) begin
            LINK.lock_n              = 1'b1;
            LINK.bus_status_lines    = xcp_pkg::STATUS_RST;
            LINK.fetch_or_ack_select = 1'b0;
            LINK.bus_grant_ack       = 1'b0;
            LINK.ext_operand_ack_n   = 1'b1;
            LINK.ext_operand_ack_oe  = 1'b1;
        end
    end
endmodule : xcp_event_unit

/* File: verilog/xcp_pkg.sv */
// Package of constants shared by the event unit and its system-side partner
package xcp_pkg;
    // Vector supplied internally for the non-maskable interrupt
    localparam logic [7:0] NMI_VECTOR        = 8'h02;
    // Vector used for the processor extension (coprocessor error) interrupt
    localparam logic [7:0] PEXT_VECTOR       = 8'h10;
    // Width of the acknowledge vector
    localparam int         VEC_W             = 8;
    // Number of acknowledge bus cycles for a maskable interrupt
    localparam int         ACK_CYCLES        = 2;
    // Least low and high widths of the non-maskable input, in clocks
    localparam int         NMI_MIN_CLKS      = 4;
    // Reset must be held longer than this many clocks
    localparam int         RESET_MIN_CLKS    = 16;
    // Initialisation clocks after reset release before first fetch
    localparam int         INIT_CLKS         = 50;
    // Clocks one acknowledge bus cycle takes on the link
    localparam int         ACK_CYC_CLKS      = 2;
    // Address width
    localparam int         ADDR_W            = 24;
    // Reset levels of the bus pins
    localparam logic [1:0] STATUS_RST        = 2'h3;
    localparam logic [23:0] ADDR_RST         = 24'hFFFFFF;
endpackage : xcp_pkg

/* File: verilog/xcp_link_if.sv */
// Interface joining the event unit and the system-side partner
`timescale 1ns/100ps
interface xcp_link_if;
    logic                 maskable_irq;         // Level request, high active
    logic                 nmi;                  // Edge request, high active
    logic                 ext_operand_request;  // Coprocessor operand request
    logic                 ext_operand_ack_n;    // Operand ack, low active
    logic                 ext_operand_ack_oe;   // Ack output enable
    logic                 busy_n;               // Coprocessor busy, low active
    logic                 error_n;              // Coprocessor error, low active
    logic                 reset;                // System reset, high active
    logic                 hold;                 // Bus request
    logic                 bus_grant_ack;        // Bus grant acknowledge
    logic [1:0]           bus_status_lines;     // Bus status
    logic                 mem_io_select;        // Memory versus IO
    logic                 fetch_or_ack_select;  // Code versus acknowledge
    logic [23:0]          addr;                 // Address lines
    logic                 upper_byte_enable_n;  // Upper byte enable
    logic                 lock_n;               // Bus lock
    logic                 inta_strobe;          // Acknowledge cycle strobe
    logic [7:0]           vector;               // Vector from controller
    logic                 ext_operand_ack_wire; // Resolved ack level (pull-up)
    assign ext_operand_ack_wire = ext_operand_ack_oe ? ext_operand_ack_n : 1'b1;
    modport dev (input maskable_irq, nmi, ext_operand_request, busy_n, error_n, reset,
                 hold, vector,
                 output ext_operand_ack_n, ext_operand_ack_oe, bus_grant_ack,
                 bus_status_lines, mem_io_select, fetch_or_ack_select, addr,
                 upper_byte_enable_n, lock_n, inta_strobe);
    modport sys (output maskable_irq, nmi, ext_operand_request, busy_n, error_n, reset,
                 hold, vector,
                 input ext_operand_ack_wire, bus_grant_ack, bus_status_lines,
                 mem_io_select, fetch_or_ack_select, inta_strobe);
endinterface : xcp_link_if

/* File: verilog/xcp_sync.sv */
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
module xcp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Data
    input  wire logic [W-1:0] d_i,
    input  wire logic [W-1:0] rst_val_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta; // First stage, read only by second stage

    // Two flops per bit
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta <= rst_val_i;
            q_o  <= rst_val_i;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule : xcp_sync

/* File: verilog/xcp_system_end.sv */
// System-side partner: interrupt controller, coprocessor and reset generator
`timescale 1ns/100ps
module xcp_system_end (
    // Clock and reset
    input  wire logic       CLK_SYS_I,
    input  wire logic       RST_N_I,
    // Link to event unit
    xcp_link_if.sys         LINK,
    // User requests
    input  wire logic       IRQ_REQ_I,
    input  wire logic [7:0] IRQ_VECTOR_I,
    input  wire logic       NMI_REQ_I,
    input  wire logic       OPERAND_REQ_I,
    input  wire logic       COPROC_BUSY_I,
    input  wire logic       COPROC_ERROR_I,
    input  wire logic       BUS_REQ_I,
    input  wire logic       RESET_REQ_I,
    // Status
    output logic            IRQ_PENDING_O,
    output logic            NMI_BUSY_O,
    output logic            RESET_BUSY_O
);
    logic [2:0] nmi_cnt;    // Width counter for non-maskable pulse
    logic [1:0] nmi_phase;  // 0 idle-low, 1 high, 2 low recovery
    logic [4:0] rst_cnt;    // Reset hold counter
    logic       irq_pend;   // Maskable request latched

    // RULE_03 hold request until acknowledge starts
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            irq_pend <= 1'b0;
        end else if (IRQ_REQ_I) begin
            irq_pend <= 1'b1;
        end else if (LINK.inta_strobe) begin
            irq_pend <= 1'b0;
        end
    end

    // RULE_10 low four then high four clocks
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            nmi_phase <= 2'h2;
            nmi_cnt   <= 3'h0;
        end else if (nmi_phase == 2'h0) begin
            nmi_cnt <= 3'h0;
            if (NMI_REQ_I) begin
                nmi_phase <= 2'h1;
            end
        end else if (nmi_cnt == 3'(xcp_pkg::NMI_MIN_CLKS - 1)) begin
            nmi_cnt   <= 3'h0;
            nmi_phase <= (nmi_phase == 2'h1) ? 2'h2 : 2'h0;
        end else begin
            nmi_cnt <= nmi_cnt + 3'h1;
        end
    end

    // RULE_18 RULE_21 reset held long, released on clock
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            rst_cnt <= 5'(xcp_pkg::RESET_MIN_CLKS + 1);
        end else if (RESET_REQ_I && rst_cnt == 5'h00) begin
            rst_cnt <= 5'(xcp_pkg::RESET_MIN_CLKS + 1);
        end else if (rst_cnt != 5'h00) begin
            rst_cnt <= rst_cnt - 5'h01;
        end
    end

    // Pin drive
    always_comb begin
        LINK.maskable_irq        = irq_pend;
        LINK.nmi                 = (nmi_phase == 2'h1);
        // RULE_11 operand request
        LINK.ext_operand_request = OPERAND_REQ_I;
        LINK.busy_n              = !COPROC_BUSY_I;
        LINK.error_n             = !COPROC_ERROR_I;
        LINK.hold                = BUS_REQ_I;
        LINK.vector              = IRQ_VECTOR_I;
        LINK.reset               = (rst_cnt != 5'h00);
    end

    assign IRQ_PENDING_O = irq_pend;
    assign NMI_BUSY_O    = (nmi_phase != 2'h0);
    assign RESET_BUSY_O  = (rst_cnt != 5'h00);
endmodule : xcp_system_end

/* File: bench/xcp_link_sva.sv */
// Checker on the link between the event unit and its system-side partner
`timescale 1ns/100ps
module xcp_link_sva (
    // Clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    // System-driven link signals
    input  wire logic        maskable_irq,
    input  wire logic        nmi,
    input  wire logic        ext_operand_request,
    input  wire logic        reset,
    input  wire logic        hold,
    // Device-driven link signals
    input  wire logic        ext_operand_ack_oe,
    input  wire logic        ext_operand_ack_wire,
    input  wire logic        bus_grant_ack,
    input  wire logic [1:0]  bus_status_lines,
    input  wire logic        mem_io_select,
    input  wire logic        fetch_or_ack_select,
    input  wire logic [23:0] addr,
    input  wire logic        upper_byte_enable_n,
    input  wire logic        lock_n,
    input  wire logic        inta_strobe
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    // Cycles reset has stayed high; starts at zero so no unknown reaches the check
    logic [7:0] rst_len = 8'h00;

    // Saturating count, free of the bench reset so the whole pulse is seen
    always_ff @(posedge CLK_SYS_I) begin
        if (!reset) begin
            rst_len <= 8'h00;
        end else if (rst_len != 8'hFF) begin
            rst_len <= rst_len + 8'h01;
        end
    end

    AST_RESET_HIGH_PINS: assert property (reset && $past(reset) |-> bus_status_lines == 2'h3
        && &addr && upper_byte_enable_n && lock_n && ext_operand_ack_oe && ext_operand_ack_wire)
        else $error("pin not high during reset");
    AST_RESET_LOW_PINS: assert property (reset && $past(reset) |->
        !mem_io_select && !fetch_or_ack_select && !bus_grant_ack)
        else $error("select or grant not low during reset");
    AST_RESET_LENGTH: assert property ($fell(reset) |-> rst_len > 8'h10)
        else $error("reset pulse too short");
    AST_ACK_TWO_CYCLES: assert property ($rose(inta_strobe) |-> inta_strobe [*4] ##1 !inta_strobe)
        else $error("acknowledge strobe not four clocks");
    AST_ACK_STATUS: assert property (inta_strobe |-> bus_status_lines == 2'h0
        && !mem_io_select && !fetch_or_ack_select)
        else $error("wrong status during acknowledge");
    AST_ACK_CAUSE: assert property ($rose(inta_strobe) |-> $past(maskable_irq, 3))
        else $error("acknowledge without request");
    AST_NMI_NO_ACK: assert property ($rose(nmi) |->
        (!$rose(inta_strobe) || $past(maskable_irq, 3)) [*8])
        else $error("acknowledge cycle on non-maskable");
    AST_NMI_WIDTH: assert property ($rose(nmi) |-> !$past(nmi, 2) && !$past(nmi, 4) ##0 nmi [*4])
        else $error("non-maskable pulse too narrow");
    AST_GRANT_FLOATS_ACK: assert property (bus_grant_ack |-> !ext_operand_ack_oe && ext_operand_ack_wire)
        else $error("ack driven under bus grant");
    AST_GRANT_FOLLOWS: assert property ((hold && !reset) [*4] |-> bus_grant_ack)
        else $error("grant missing under held request");
    AST_ACK_NEEDS_REQ: assert property (!ext_operand_ack_wire |-> $past(ext_operand_request, 2))
        else $error("operand ack without request");
endmodule : xcp_link_sva

/* File: bench/test_cpu_interrupt_coproc_reset_pins.sv */
// Self-checking bench for the event unit facing its system-side partner
`timescale 1ns/100ps
module test_cpu_interrupt_coproc_reset_pins;
    localparam int P_INIT = 4;              // Shortened initialisation so runs stay brief
    logic        clk, rst_n;                // Clock and bench reset
    logic        en, instr, xfer;           // Core side controls
    logic        init_done, stall, taken;   // Core side results
    logic [7:0]  vec, irq_vec;              // Taken and offered vectors
    logic        irq_req, nmi_req, op_req;  // Partner requests
    logic        busy, err, bus_req, rst_req; // Partner levels
    logic        pend;                      // Maskable request still held
    logic        nmi_busy, rst_busy;        // Partner pulse and reset activity
    logic [31:0] seed = 32'h5CD8;           // Random state
    logic [15:0] exp_q[$];                  // Model: strobe count and vector per take
    int          err_count = 0;             // Mismatches
    int          cmp_count = 0;             // Comparisons
    int          ack_seen = 0;              // Strobe clocks since the last take
    int          n;                         // Measured clocks

    xcp_link_if link ();
    xcp_event_unit #(.INIT_CLKS(P_INIT)) i_xcp_event_unit (.CLK_SYS_I(clk), .RST_N_I(rst_n),
        .LINK(link), .INT_ENABLE_I(en), .COPROC_OPCODE_INSTR_I(instr), .OPERAND_XFER_I(xfer),
        .INIT_DONE_O(init_done), .STALL_O(stall), .INT_TAKEN_O(taken), .INT_VECTOR_O(vec));
    xcp_system_end i_xcp_system_end (.CLK_SYS_I(clk), .RST_N_I(rst_n), .LINK(link),
        .IRQ_REQ_I(irq_req), .IRQ_VECTOR_I(irq_vec), .NMI_REQ_I(nmi_req),
        .OPERAND_REQ_I(op_req), .COPROC_BUSY_I(busy), .COPROC_ERROR_I(err),
        .BUS_REQ_I(bus_req), .RESET_REQ_I(rst_req), .IRQ_PENDING_O(pend),
        .NMI_BUSY_O(nmi_busy), .RESET_BUSY_O(rst_busy));
    xcp_link_sva i_xcp_link_sva (.CLK_SYS_I(clk), .RST_N_I(rst_n),
        .maskable_irq(link.maskable_irq), .nmi(link.nmi),
        .ext_operand_request(link.ext_operand_request), .reset(link.reset), .hold(link.hold),
        .ext_operand_ack_oe(link.ext_operand_ack_oe),
        .ext_operand_ack_wire(link.ext_operand_ack_wire), .bus_grant_ack(link.bus_grant_ack),
        .bus_status_lines(link.bus_status_lines), .mem_io_select(link.mem_io_select),
        .fetch_or_ack_select(link.fetch_or_ack_select), .addr(link.addr),
        .upper_byte_enable_n(link.upper_byte_enable_n), .lock_n(link.lock_n),
        .inta_strobe(link.inta_strobe));

    // Compare one value and tally it
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // Report counts and end the run
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // Advance n clocks and land just after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // Bounded wait until every expected take has been seen
    task automatic drain();
        for (int i = 0; i < 200 && exp_q.size() != 0; i++) begin
            step(1);
        end
        if (exp_q.size() != 0) begin
            check("missing take", 16'h0, exp_q[0]);
            tally_and_finish();
        end
    endtask : drain

    // Bounded wait from reset release to the end of initialisation
    task automatic wait_init(output int n);
        for (int i = 0; i < 200 && link.reset !== 1'b0; i++) begin
            step(1);
        end
        for (n = 0; n < 200 && init_done !== 1'b1; n++) begin
            step(1);
        end
        if (init_done !== 1'b1) begin
            check("init done", 16'h1, 16'h0);
            tally_and_finish();
        end
    endtask : wait_init

    // Xorshift source for vectors
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : xs

    // Packed pin state: all ones on the high group, zeros on selects, no init yet
    function automatic logic [15:0] pins();
        return {6'h0, link.bus_status_lines, link.ext_operand_ack_wire, link.lock_n,
            link.upper_byte_enable_n, &link.addr, link.mem_io_select,
            link.fetch_or_ack_select, link.bus_grant_ack, init_done};
    endfunction : pins

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Model check at mid-cycle, where registered pulses have settled
    always @(negedge clk) begin
        if (link.inta_strobe === 1'b1) begin
            ack_seen++;
        end
        if (taken === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spurious take", 16'h0, {8'h1, vec});
            end else begin
                check("take", exp_q.pop_front(), {ack_seen[7:0], vec});
            end
            ack_seen = 0;
        end
    end

    initial begin
        {rst_n, en, instr, xfer, irq_req, nmi_req, op_req} = 7'h0;
        {busy, err, bus_req, rst_req} = 4'h0;
        irq_vec = 8'h00;
        step(10);
        rst_n = 1'b1;
        step(3);
        check("reset pins", 16'h03F0, pins());
        wait_init(n);
        check("init clocks", 16'h1, {15'h0, n >= P_INIT});
        // Masked request must wait, held by the controller, until enabled
        irq_vec = xs();
        irq_req = 1'b1;
        step(1);
        irq_req = 1'b0;
        step(30);
        check("request held", 16'h1, {15'h0, pend});
        exp_q.push_back({8'h4, irq_vec});
        en = 1'b1;
        drain();
        // Three enabled requests in turn, each drained before the next, with random vectors
        for (int k = 0; k < 3; k++) begin
            irq_vec = xs();
            exp_q.push_back({8'h4, irq_vec});
            irq_req = 1'b1;
            step(1);
            irq_req = 1'b0;
            drain();
        end
        // Non-maskable twice with the enable clear; no strobes expected
        en = 1'b0;
        for (int k = 0; k < 2; k++) begin
            exp_q.push_back({8'h0, xcp_pkg::NMI_VECTOR});
            nmi_req = 1'b1;
            step(1);
            nmi_req = 1'b0;
            check("nmi busy", 16'h1, {15'h0, nmi_busy});
            drain();
            step(12);
        end
        // Busy stall, with an interrupt taken while stalled
        en = 1'b1;
        instr = 1'b1;
        busy = 1'b1;
        step(4);
        check("stall", 16'h1, {15'h0, stall});
        irq_vec = xs();
        exp_q.push_back({8'h4, irq_vec});
        irq_req = 1'b1;
        step(1);
        irq_req = 1'b0;
        drain();
        busy = 1'b0;
        step(4);
        check("stall released", 16'h0, {15'h0, stall});
        // Error pulse during a coprocessor instruction
        exp_q.push_back({8'h0, xcp_pkg::PEXT_VECTOR});
        err = 1'b1;
        step(1);
        err = 1'b0;
        drain();
        instr = 1'b0;
        // Operand handshake, then a bus grant that floats the ack
        op_req = 1'b1;
        xfer = 1'b1;
        step(4);
        check("ack low", 16'h0, {15'h0, link.ext_operand_ack_wire});
        bus_req = 1'b1;
        step(4);
        check("ack float", 16'h3, {14'h0, link.bus_grant_ack, link.ext_operand_ack_wire});
        bus_req = 1'b0;
        step(4);
        check("grant off", 16'h0, {14'h0, link.bus_grant_ack, link.ext_operand_ack_wire});
        {op_req, xfer} = 2'h0;
        // Reset in mid-run
        rst_req = 1'b1;
        step(1);
        rst_req = 1'b0;
        step(4);
        check("mid-run reset pins", 16'h03F0, pins());
        check("reset busy", 16'h1, {15'h0, rst_busy});
        wait_init(n);
        check("reinit clocks", 16'h1, {15'h0, n >= P_INIT});
        check("reset busy end", 16'h0, {15'h0, rst_busy});
        step(10);
        tally_and_finish();
    end
endmodule : test_cpu_interrupt_coproc_reset_pins
